// ### logic/fls_err_flags.sv
/*
  Program and erase error flags of the sequencer status.
  Assumes set and clear strobes come from logic on the same clock.
*/
module fls_err_flags
  import fls_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic set_prog,
  input  wire logic set_erase,
  input  wire logic clr,
  output logic      prog_err,
  output logic      erase_err
);

  // Set beats clear so an error raised in the clear cycle survives
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prog_err  <= RST_PROG_ERR;
      erase_err <= RST_ERASE_ERR;
    end
    else
    begin
      prog_err  <= set_prog  | (prog_err  & ~clr);
      erase_err <= set_erase | (erase_err & ~clr);
    end
  end

endmodule

// ### logic/fls_pkg.sv
/*
  Package of the flash command sequencer: command codes, address layout,
  reset values, modes and the structs that carry bus and core requests.
  Assumes one 50 MHz clock domain shared by the CPU bus and the flash core.
*/
package fls_pkg;

  // ****************************************************
  // Sizes and address layout
  // ****************************************************
  localparam int ADDR_W   = 20;
  localparam int NUM_BLK  = 16;
  localparam int BLK_LSB  = 16;
  localparam int NUM_PROT = 8;
  // Base of the protect bit address window; value is arbitrary
  localparam logic [ADDR_W-1:0] PROT_BASE = 20'hFFFF0;
  localparam logic [ADDR_W-1:0] WORD_STEP = 20'h00002;

  // ****************************************************
  // Command codes (low byte of a command write)
  // ****************************************************
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0] CMD_PROGRAM     = 8'h41;
  localparam logic [7:0] CMD_ERASE       = 8'h20;
  localparam logic [7:0] CMD_LOCK_PROG   = 8'h77;
  localparam logic [7:0] CMD_LOCK_READ   = 8'h71;
  localparam logic [7:0] CMD_PROT_PROG   = 8'h67;
  localparam logic [7:0] CMD_PROT_READ   = 8'h61;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;

  // ****************************************************
  // Status byte fields and reset values
  // ****************************************************
  localparam int ST_PROG_BIT   = 4;
  localparam int ST_ERASE_BIT  = 5;
  localparam int ST_READY_BIT  = 7;
  localparam int RD_FLAG_BIT   = 6;
  localparam logic RST_PROG_ERR  = 1'b0;
  localparam logic RST_ERASE_ERR = 1'b0;
  localparam logic [NUM_BLK-1:0]  RST_LOCK_BITS = 16'hFFFF;
  localparam logic [NUM_PROT-1:0] RST_PROT_BITS = 8'hFF;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {MD_ARRAY, MD_STATUS, MD_LOCK_RD, MD_PROT_RD}
    fls_mode_t;
  typedef enum logic [2:0] {PD_NONE, PD_PROG1, PD_PROG2, PD_ERASE, PD_LOCK,
    PD_LKRD, PD_PBP} fls_pend_t;
  typedef enum logic [1:0] {OP_PROG, OP_ERASE, OP_LOCK, OP_PBP} fls_op_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
  } fls_bus_req_t;

  typedef struct packed {
    logic              start;
    fls_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } fls_core_req_t;

endpackage

// ### logic/fls_seq.sv
/*
  Flash command sequencer: decodes 16-bit CPU command writes, runs
  program, erase, lock bit and protect bit operations on the flash core,
  and answers reads with array data, status or lock/protect state.
  Assumes the core answers each start with one core_done pulse and that
  all inputs come from logic on mclk.
*/

// Function
// - 77h then D0h locks addressed block
// - Ready low while lock program runs
// - CPU-running mode enters status read on start
// - Path one: 71h D0h captures lock bit
// - Path zero: 71h then read gives bit6
// - 67h then D0h clears protect bit
// - After 61h read returns protect bit6
// - Stay in protect status read mode
// - Status read after op commands, mirrored
// - Status byte b4 b5 b7 layout
// - Error flags block most commands
// - Bad sequence sets both error flags
// - Locked or failed erase gives erase error
// - Locked or failed program gives program error
// - 16-bit even accesses, upper byte ignored
// - FFh returns to array read
// - FFh second write aborts silently; after 41h the code takes FFh as program data instead
// - Lock disable suppresses locked errors
module fls_seq
  import fls_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          resetn,
  input  fls_bus_req_t       bus_req,
  output logic [15:0]        bus_rdata,
  output logic               bus_rvalid,
  output fls_core_req_t      core_req,
  input  wire logic          core_done,
  input  wire logic          core_fail,
  input  wire logic [15:0]   array_rdata,
  input  wire logic          cpu_running_rewrite_mode,
  input  wire logic          cpu_hold_rewrite_mode,
  input  wire logic          lock_disable_bit,
  input  wire logic          lock_read_path_select,
  output logic               sequencer_ready_flag,
  output logic               program_error_flag,
  output logic               erase_error_flag,
  output logic               lock_status_capture_bit
);

  // ****************************************************
  // Address decoding helpers
  // ****************************************************
  function automatic logic [3:0] blk_of(input logic [ADDR_W-1:0] a);
    blk_of = a[ADDR_W-1:BLK_LSB];
  endfunction

  function automatic logic is_top(input logic [ADDR_W-1:0] a);
    is_top = &a[BLK_LSB-1:1];
  endfunction

  function automatic logic is_pba(input logic [ADDR_W-1:0] a);
    is_pba = (a[ADDR_W-1:4] == PROT_BASE[ADDR_W-1:4]);
  endfunction

  // ****************************************************
  // State
  // ****************************************************
  fls_mode_t            mode_q, mode_d;
  fls_pend_t            pend_q, pend_d;
  fls_op_t              op_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [ADDR_W-1:0]    op_addr_q;
  logic [15:0]          wd0_q;
  logic                 core_busy_q;
  logic                 lkrd_busy_q;
  logic [NUM_BLK-1:0]   lock_bits_q;
  logic [NUM_PROT-1:0]  prot_bits_q;
  logic                 wr;
  logic [7:0]           code;
  logic                 err_any;
  logic                 seq_err;
  logic                 clr_err;
  logic                 go;
  fls_op_t              go_op;
  logic [ADDR_W-1:0]    go_addr;
  logic                 lkrd_go;
  logic                 locked;
  logic                 lock_err;
  logic                 start;
  logic                 op_ok;
  logic                 op_bad;
  logic [3:0]           op_blk;
  logic                 lkbit_rd;
  logic [7:0]           status;

  // Writes during a running operation are dropped, not queued
  assign wr      = bus_req.wr & ~core_busy_q & ~lkrd_busy_q;
  assign code    = bus_req.wdata[7:0];
  assign err_any = program_error_flag | erase_error_flag;
  assign op_blk  = blk_of(op_addr_q);
  assign lkbit_rd = lock_bits_q[blk_of(bus_req.addr)];
  assign op_ok   = core_done & ~core_fail;
  assign op_bad  = core_done & core_fail;
  assign sequencer_ready_flag = ~(core_busy_q | lkrd_busy_q);
  assign status = {sequencer_ready_flag, 1'b0, erase_error_flag,
                   program_error_flag, 4'h0};

  // ****************************************************
  // Command decode
  // ****************************************************
  always_comb
  begin
    pend_d  = pend_q;
    mode_d  = mode_q;
    seq_err = 1'b0;
    clr_err = 1'b0;
    go      = 1'b0;
    go_op   = OP_PROG;
    go_addr = bus_req.addr;
    lkrd_go = 1'b0;
    if (wr && pend_q == PD_NONE)
    begin
      case (code)
        CMD_READ_ARRAY:  mode_d = MD_ARRAY;
        CMD_READ_STATUS: mode_d = MD_STATUS;
        CMD_CLEAR_STAT:  clr_err = 1'b1;
        CMD_PROGRAM:     if (!err_any) pend_d = PD_PROG1;
        CMD_ERASE:       if (!err_any) pend_d = PD_ERASE;
        CMD_LOCK_PROG:   if (!err_any) pend_d = PD_LOCK;
        CMD_LOCK_READ:
          if (!err_any)
          begin
            if (lock_read_path_select)
              pend_d = PD_LKRD;
            else
              mode_d = MD_LOCK_RD;
          end
        CMD_PROT_PROG:   if (!err_any) pend_d = PD_PBP;
        CMD_PROT_READ:   mode_d = MD_PROT_RD;
        default:         seq_err = 1'b1;
      endcase
    end
    else if (wr && code == CMD_READ_ARRAY && pend_q != PD_PROG1
             && pend_q != PD_PROG2)
    begin
      pend_d = PD_NONE;
      mode_d = MD_ARRAY;
    end
    else if (wr)
    begin
      pend_d = PD_NONE;
      case (pend_q)
        PD_PROG1:
          if (bus_req.addr == addr_q && addr_q[1:0] == 2'b00)
            pend_d = PD_PROG2;
          else
            seq_err = 1'b1;
        PD_PROG2:
          if (bus_req.addr == addr_q + WORD_STEP)
          begin
            go      = 1'b1;
            go_addr = addr_q;
          end
          else
            seq_err = 1'b1;
        PD_ERASE:
          if (code == CMD_CONFIRM && is_top(bus_req.addr))
          begin
            go    = 1'b1;
            go_op = OP_ERASE;
          end
          else
            seq_err = 1'b1;
        PD_LOCK:
          if (code == CMD_CONFIRM && bus_req.addr == addr_q
              && is_top(bus_req.addr))
          begin
            go    = 1'b1;
            go_op = OP_LOCK;
          end
          else
            seq_err = 1'b1;
        PD_LKRD:
          if (code == CMD_CONFIRM && is_top(bus_req.addr))
            lkrd_go = 1'b1;
          else
            seq_err = 1'b1;
        PD_PBP:
          if (code == CMD_CONFIRM && bus_req.addr == addr_q
              && is_pba(bus_req.addr))
          begin
            go    = 1'b1;
            go_op = OP_PBP;
          end
          else
            seq_err = 1'b1;
        default: ;
      endcase
    end
    if (go && cpu_running_rewrite_mode)
      mode_d = MD_STATUS;
    else if (wr && pend_q == PD_NONE && code != CMD_READ_ARRAY
             && code != CMD_PROT_READ && code != CMD_LOCK_READ
             && code != CMD_CLEAR_STAT && !seq_err && !err_any)
      mode_d = MD_STATUS;
    if (core_done && cpu_hold_rewrite_mode)
      mode_d = MD_ARRAY;
  end

  // Locked program and erase targets fail at once without touching the core
  assign locked   = ~lock_bits_q[blk_of(go_addr)] & ~lock_disable_bit;
  assign lock_err = go & locked & (go_op == OP_PROG || go_op == OP_ERASE);
  assign start    = go & ~lock_err;

  // ****************************************************
  // Sequencer registers
  // ****************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_q <= MD_ARRAY;
      pend_q <= PD_NONE;
      addr_q <= '0;
      wd0_q  <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      pend_q <= pend_d;
      if (wr && pend_q == PD_NONE)
        addr_q <= bus_req.addr;
      if (wr && pend_q == PD_PROG1)
        wd0_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_busy_q <= 1'b0;
      lkrd_busy_q <= 1'b0;
      op_q        <= OP_PROG;
      op_addr_q   <= '0;
      core_req    <= '0;
    end
    else
    begin
      lkrd_busy_q    <= lkrd_go;
      core_req.start <= start;
      if (start)
      begin
        core_busy_q    <= 1'b1;
        op_q           <= go_op;
        op_addr_q      <= go_addr;
        core_req.op    <= go_op;
        core_req.addr  <= go_addr;
        core_req.wdata <= {bus_req.wdata, wd0_q};
      end
      else if (core_done)
        core_busy_q <= 1'b0;
    end
  end

  // ****************************************************
  // Lock and protect bits
  // ****************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_bits_q <= RST_LOCK_BITS;
      prot_bits_q <= RST_PROT_BITS;
      lock_status_capture_bit <= 1'b0;
    end
    else
    begin
      if (op_ok && op_q == OP_LOCK)
        lock_bits_q[op_blk] <= 1'b0;
      if (op_ok && op_q == OP_PBP)
        prot_bits_q[op_addr_q[3:1]] <= 1'b0;
      if (lkrd_go)
        lock_status_capture_bit <= lkbit_rd;
    end
  end

  fls_err_flags u_err (
    .mclk      (mclk),
    .resetn    (resetn),
    .set_prog  (seq_err | (lock_err & go_op == OP_PROG)
                | (op_bad & op_q != OP_ERASE)),
    .set_erase (seq_err | (lock_err & go_op == OP_ERASE)
                | (op_bad & op_q == OP_ERASE)),
    .clr       (clr_err),
    .prog_err  (program_error_flag),
    .erase_err (erase_error_flag)
  );

  // ****************************************************
  // Read path
  // ****************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_rvalid <= 1'b0;
      bus_rdata  <= '0;
    end
    else
    begin
      bus_rvalid <= bus_req.rd;
      if (bus_req.rd)
      begin
        case (mode_q)
          MD_ARRAY:   bus_rdata <= array_rdata;
          MD_STATUS:  bus_rdata <= {8'h00, status};
          MD_LOCK_RD: bus_rdata <= {9'h000, lkbit_rd, 6'h00};
          MD_PROT_RD: bus_rdata <= {9'h000, prot_bits_q[bus_req.addr[3:1]],
                                    6'h00};
          default:    bus_rdata <= '0;
        endcase
      end
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  lock_clear_a: assert property ((op_ok && op_q == OP_LOCK) |=>
    lock_bits_q[$past(op_blk)] == 1'b0) else $error("lock bit not cleared");
  busy_low_a: assert property (start |=> core_req.start
    && !sequencer_ready_flag) else $error("ready high after start");
  ready_back_a: assert property ((core_done && core_busy_q)
    |=> sequencer_ready_flag) else $error("ready low after done");
  ew0_status_a: assert property ((start && cpu_running_rewrite_mode)
    |=> mode_q == MD_STATUS) else $error("no status mode on start");
  sequence lkrd_s;
    !sequencer_ready_flag ##1 (sequencer_ready_flag
    && lock_status_capture_bit == $past(lkbit_rd, 2));
  endsequence
  lkrd_capture_a: assert property (lkrd_go |=> lkrd_s)
    else $error("lock capture wrong");
  lock_rd_a: assert property ((bus_req.rd && mode_q == MD_LOCK_RD)
    |=> bus_rvalid && bus_rdata[RD_FLAG_BIT] == $past(lkbit_rd))
    else $error("lock read bit6 wrong");
  err_block_a: assert property ((wr && pend_q == PD_NONE && err_any
    && code != CMD_READ_ARRAY) |=> pend_q == PD_NONE && !core_req.start)
    else $error("command taken while error set");
  seq_err_a: assert property (seq_err |=> program_error_flag
    && erase_error_flag) else $error("sequence error not flagged");
  status_byte_a: assert property ((bus_req.rd && mode_q == MD_STATUS)
    |=> bus_rdata[ST_READY_BIT] == $past(sequencer_ready_flag)
    && bus_rdata[ST_ERASE_BIT] == $past(erase_error_flag)
    && bus_rdata[ST_PROG_BIT] == $past(program_error_flag))
    else $error("status byte wrong");
  ff_abort_a: assert property ((wr && code == CMD_READ_ARRAY
    && (pend_q == PD_LOCK || pend_q == PD_ERASE)) |=> mode_q == MD_ARRAY
    && pend_q == PD_NONE && $stable(program_error_flag))
    else $error("FF abort wrong");

endmodule

// ### tb/fls_core_model.sv
/*
  Behavioural flash core that answers sequencer start pulses.
  Assumes start pulses come from the sequencer on mclk, one op at a time.
*/
module fls_core_model
  import fls_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  fls_core_req_t   core_req,
  input  wire logic       fail_en,
  input  wire logic [7:0] delay,
  output logic            core_done,
  output logic            core_fail
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cnt_q;
  logic       run_q;

  // ****************************************************
  // Operation timer
  // ****************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end
    else if (core_req.start)
    begin
      run_q <= 1'b1;
      cnt_q <= delay;
    end
    else if (run_q && cnt_q == 8'h00)
      run_q <= 1'b0;
    else if (run_q)
      cnt_q <= cnt_q - 8'h01;
  end

  // Fail is only meaningful with done; it toggles otherwise so no
  // stale level can be mistaken for a result
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_done <= 1'b0;
      core_fail <= 1'b0;
    end
    else
    begin
      core_done <= run_q && cnt_q == 8'h00 && !core_req.start;
      core_fail <= (run_q && cnt_q == 8'h00) ? fail_en : ~core_fail;
    end
  end
endmodule

// ### tb/tb_top.sv
/*
  Self-checking bench of the flash command sequencer.
  Assumes the core model answers every start; array data is a pattern
  derived from the read address.
*/
module tb_top
  import fls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          mclk = 1'b0;
  logic          resetn = 1'b0;
  fls_bus_req_t  bus_req = '0;
  logic [15:0]   bus_rdata;
  logic          bus_rvalid;
  fls_core_req_t core_req;
  logic          core_done;
  logic          core_fail;
  logic [15:0]   array_rdata;
  logic          run_md = 1'b1;
  logic          hold_md = 1'b0;
  logic          lock_dis = 1'b0;
  logic          path_sel = 1'b0;
  logic          rdy;
  logic          perr;
  logic          eerr;
  logic          cap;
  logic          fail_en = 1'b0;
  logic [7:0]    delay = 8'h06;
  logic [15:0]   d;
  fls_op_t       last_op;
  logic [19:0]   last_addr;
  logic [31:0]   last_wd;
  int            n_starts = 0;
  int            n0;
  int            n_errors = 0;
  int            check_count = 0;

  always #10 mclk = ~mclk;
  assign array_rdata = bus_req.addr[15:0] ^ 16'h5A5A;

  always @(posedge mclk)
  begin
    if (core_req.start === 1'b1)
    begin
      n_starts++;
      last_op = core_req.op;
      last_addr = core_req.addr;
      last_wd = core_req.wdata;
    end
  end

  fls_seq dut_u (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .core_req(core_req),
    .core_done(core_done), .core_fail(core_fail), .array_rdata(array_rdata),
    .cpu_running_rewrite_mode(run_md), .cpu_hold_rewrite_mode(hold_md),
    .lock_disable_bit(lock_dis), .lock_read_path_select(path_sel),
    .sequencer_ready_flag(rdy), .program_error_flag(perr),
    .erase_error_flag(eerr), .lock_status_capture_bit(cap));

  fls_core_model core_u (.mclk(mclk), .resetn(resetn), .core_req(core_req),
    .fail_en(fail_en), .delay(delay), .core_done(core_done),
    .core_fail(core_fail));

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [19:0] top(input logic [3:0] b);
    return {b, 16'hFFFE};
  endfunction

  function automatic logic [19:0] pba(input logic [2:0] i);
    return {16'hFFFF, i, 1'b0};
  endfunction

  function automatic logic [15:0] st(input logic p, e, r);
    return {8'h00, r, 1'b0, e, p, 4'h0};
  endfunction

  task automatic end_sim();
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic timed_out();
    chk(1'b0, 1'b1, "wait timed out");
    end_sim();
  endtask

  task automatic wr(input logic [19:0] a, input logic [15:0] w);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, output logic [15:0] r);
    int i;
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      #1;
      if (bus_rvalid === 1'b1)
        break;
      @(posedge mclk);
    end
    if (i == 4)
      timed_out();
    r = bus_rdata;
  endtask

  task automatic wait_rdy();
    int i;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk);
      #1;
      if (rdy === 1'b1)
        break;
    end
    if (i == 50)
      timed_out();
  endtask

  task automatic flags(input logic p, e, input string msg);
    chk({perr, eerr}, {p, e}, msg);
  endtask

  task automatic clr();
    wr(20'h00000, 16'h0050);
    @(posedge mclk);
    #1;
    flags(1'b0, 1'b0, "flags not cleared");
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    rd(20'h10040, d);
    chk(d, 16'h5A5A ^ 16'h0040, "array read after reset");
    flags(1'b0, 1'b0, "error flags after reset");
    wr(top(4'h0), 16'hAB70);
    rd(20'h00010, d);
    chk(d, st(1'b0, 1'b0, 1'b1), "status after reset");
  endtask

  task automatic t_lock();
    n0 = n_starts;
    wr(top(4'h3), 16'h0077);
    wr(top(4'h3), 16'h00D0);
    #1;
    chk(rdy, 1'b0, "ready during lock program");
    rd(20'h50020, d);
    chk(d, st(1'b0, 1'b0, 1'b0), "busy status in running mode");
    wait_rdy();
    chk(n_starts - n0, 1, "lock program start count");
    chk(last_op, OP_LOCK, "lock program op");
    // path_sel stays low so 71h selects the path-zero read
    wr(20'h00000, 16'h0071);
    rd(20'h30100, d);
    chk(d[6], 1'b0, "locked block bit6");
    wr(20'h00000, 16'h0071);
    rd(20'h40100, d);
    chk(d[6], 1'b1, "unlocked block bit6");
  endtask

  task automatic t_path1();
    @(posedge mclk);
    path_sel <= 1'b1;
    wr(top(4'h0), 16'h0071);
    wr(top(4'h3), 16'h00D0);
    wait_rdy();
    chk(cap, 1'b0, "capture of locked block");
    wr(top(4'h0), 16'h0071);
    wr(top(4'h4), 16'h00D0);
    wait_rdy();
    chk(cap, 1'b1, "capture of unlocked block");
    @(posedge mclk);
    path_sel <= 1'b0;
  endtask

  task automatic t_prot();
    wr(pba(3'h2), 16'h0067);
    wr(pba(3'h2), 16'h00D0);
    wait_rdy();
    chk(last_op, OP_PBP, "protect program op");
    flags(1'b0, 1'b0, "flags after protect program");
    wr(20'h00000, 16'h0061);
    rd(pba(3'h2), d);
    chk(d[6], 1'b0, "protected bit6");
    rd(pba(3'h3), d);
    chk(d[6], 1'b1, "unprotected bit6");
    rd(pba(3'h2), d);
    chk(d[6], 1'b0, "repeated protect read");
  endtask

  task automatic t_seqerr();
    wr(top(4'h1), 16'h0077);
    wr(top(4'h1), 16'h0055);
    @(posedge mclk);
    #1;
    flags(1'b1, 1'b1, "bad second write");
    n0 = n_starts;
    wr(top(4'h1), 16'h0077);
    wr(top(4'h1), 16'h00D0);
    repeat (3) @(posedge mclk);
    chk(n_starts - n0, 0, "command refused under error");
    clr();
    wr(20'h00000, 16'h0033);
    @(posedge mclk);
    #1;
    flags(1'b1, 1'b1, "unknown first code");
    wr(20'h00000, 16'h0070);
    rd(20'h20000, d);
    chk(d, st(1'b1, 1'b1, 1'b1), "status mirrors flags");
    clr();
  endtask

  task automatic t_locked_ops();
    n0 = n_starts;
    wr(20'h00000, 16'h0020);
    wr(top(4'h3), 16'h00D0);
    wait_rdy();
    flags(1'b0, 1'b1, "erase of locked block");
    clr();
    wr(20'h30000, 16'h0041);
    wr(20'h30000, 16'h1234);
    wr(20'h30002, 16'h5678);
    wait_rdy();
    flags(1'b1, 1'b0, "program of locked block");
    chk(n_starts - n0, 0, "no start on locked block");
    clr();
    @(posedge mclk);
    lock_dis <= 1'b1;
    wr(20'h00000, 16'h0020);
    wr(top(4'h3), 16'h00D0);
    wait_rdy();
    chk(last_op, OP_ERASE, "erase with lock disabled");
    flags(1'b0, 1'b0, "no error with lock disabled");
    @(posedge mclk);
    lock_dis <= 1'b0;
  endtask

  task automatic t_fail();
    @(posedge mclk);
    fail_en <= 1'b1;
    delay <= 8'h00;
    wr(top(4'h5), 16'h0077);
    wr(top(4'h5), 16'h00D0);
    wait_rdy();
    flags(1'b1, 1'b0, "failed lock program");
    clr();
    wr(20'h00000, 16'h0020);
    wr(top(4'h6), 16'h00D0);
    wait_rdy();
    flags(1'b0, 1'b1, "failed erase");
    clr();
    @(posedge mclk);
    fail_en <= 1'b0;
    delay <= 8'h06;
  endtask

  task automatic t_abort();
    n0 = n_starts;
    wr(20'h00000, 16'h0020);
    wr(top(4'h2), 16'h00FF);
    repeat (3) @(posedge mclk);
    chk(n_starts - n0, 0, "aborted erase started");
    flags(1'b0, 1'b0, "abort raised error");
    rd(20'h20040, d);
    chk(d, 16'h5A5A ^ 16'h0040, "array read after abort");
  endtask

  task automatic t_prog();
    wr(20'h40000, 16'h0041);
    wr(20'h40000, 16'h1234);
    wr(20'h40002, 16'h5678);
    wait_rdy();
    chk(last_op, OP_PROG, "program op");
    chk(last_wd[15:0], 16'h1234, "program low word");
    chk(last_wd[31:16], 16'h5678, "program high word");
    chk(last_addr[19:4], 16'h4000, "program address");
    chk(last_addr[3:0], 4'h0, "program address low bits");
    flags(1'b0, 1'b0, "flags after program");
  endtask

  task automatic t_hold();
    @(posedge mclk);
    run_md  <= 1'b0;
    hold_md <= 1'b1;
    // Rewrite program taken to sit in block 0, so block 7 is fair game
    wr(20'h00000, 16'h0020);
    wr(top(4'h7), 16'h00D0);
    wait_rdy();
    chk(last_op, OP_ERASE, "erase in hold mode");
    chk(last_addr[19:4], 16'h7FFF, "hold erase address");
    flags(1'b0, 1'b0, "flags after hold erase");
    rd(20'h70040, d);
    chk(d, 16'h5A5A ^ 16'h0040, "array read after hold erase");
    @(posedge mclk);
    run_md  <= 1'b1;
    hold_md <= 1'b0;
  endtask

  initial
  begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_lock();
    t_path1();
    t_prot();
    t_seqerr();
    t_locked_ops();
    t_fail();
    t_abort();
    t_prog();
    t_hold();
    end_sim();
  end
endmodule
